// ===== rtl/spoc_device.sv
// position output end: averaging, scaling, settings, two serial channels
// assumes link clocks idle high and come from another domain
`timescale 1ns/100ps
module spoc_device #(
    parameter int MS_CYC = spoc_pkg::MS_CYC,
    parameter int AVG_LOG2 = spoc_pkg::AVG_LOG2
) (
    input wire logic pclk,
    input wire logic presetn,
    spoc_link_if.dev link,
    input wire logic [31:0] pos_in,
    input wire logic pos_invalid,
    input wire logic quality_warn,
    input wire logic quality_loss,
    input wire logic device_err,
    input wire logic supply_ok,
    input wire logic service_mode,
    input wire logic switch_in,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_sel,
    input wire logic [15:0] cfg_wdata,
    input wire logic cfg_accept,
    input wire logic cfg_refuse,
    output logic [7:0] rb_ch_a,
    output logic [7:0] rb_ch_b,
    output logic [15:0] rb_gen,
    output logic switch_out,
    output logic ext_error,
    output logic running
);
    localparam int DEPTH = 1 << AVG_LOG2;
    localparam int SW = 32 + AVG_LOG2;
    localparam int TW = $clog2(MS_CYC + 1);

    if (AVG_LOG2 < 1 || AVG_LOG2 > 4 || MS_CYC < 2) begin : g_chk
        $error("spoc_device: unsupported parameter");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0][2:0] lsy;
        logic [2:0] isy;
        logic [TW-1:0] tick;
        logic [DEPTH-1:0][31:0] fifo;
        logic [AVG_LOG2-1:0] wp;
        logic [SW-1:0] sum;
        logic [31:0] mean;
        logic [1:0][7:0] ch_act;
        logic [1:0][7:0] ch_pend;
        logic [15:0] gen_act;
        logic [15:0] gen_pend;
        logic [8:0] react;
        logic err;
        logic [3:0] in_cnt;
        logic stopped;
        logic [3:0] out_cnt;
        logic sw_out;
        logic [7:0] start;
        logic run;
        logic [1:0] busy;
        logic [1:0][4:0] bits;
        logic [1:0][27:0] sh;
        logic [1:0][11:0] idle;
        logic [1:0] sdo;
    } spoc_dev_s;

    function automatic spoc_dev_s f_rst();
        f_rst = '0;
        f_rst.lsy = '1;
        f_rst.sdo = '1;
        f_rst.ch_act = {2{spoc_pkg::CH_CFG_RST}};
        f_rst.ch_pend = {2{spoc_pkg::CH_CFG_RST}};
        f_rst.gen_act = spoc_pkg::GEN_CFG_RST;
        f_rst.gen_pend = spoc_pkg::GEN_CFG_RST;
    endfunction

    localparam spoc_dev_s DEV_RST = f_rst();

    function automatic logic [31:0] f_div(input logic [2:0] res);
        unique case (res)
            spoc_pkg::RES_10UM: f_div = 32'h0000_0001;
            spoc_pkg::RES_1MM: f_div = 32'h0000_0064;
            default: f_div = 32'h0000_000A;
        endcase
    endfunction

    function automatic int f_width(input logic [2:0] code);
        f_width = int'(code) + (spoc_pkg::WID_BASE - spoc_pkg::WID_CODE_MIN);
    endfunction

    spoc_dev_s q;
    spoc_dev_s d;
    logic tick_p;
    logic raw;
    logic frame_err;
    logic cond;
    logic [1:0] ovf;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [31:0] scaled;
    logic [31:0] coded;
    logic [27:0] val;
    logic [7:0] cc;
    logic [11:0] mono;
    int w;
    int n;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        ovf = '0;
        rise = '0;
        fall = '0;
        scaled = '0;
        coded = '0;
        val = '0;
        cc = '0;
        mono = '0;
        w = 0;
        n = 0;
        tick_p = (q.tick == TW'(MS_CYC - 1));
        d.tick = tick_p ? '0 : q.tick + TW'(1);
        d.isy = {q.isy[1:0], switch_in};
        d.lsy[0] = {q.lsy[0][1:0], link.clk_a};
        d.lsy[1] = {q.lsy[1][1:0], link.clk_b};
        // settings: shadow copies until accepted
        if (cfg_wr) begin
            unique case (cfg_sel)
                spoc_pkg::CSEL_A: d.ch_pend[0] = cfg_wdata[7:0];
                spoc_pkg::CSEL_B: d.ch_pend[1] = cfg_wdata[7:0];
                spoc_pkg::CSEL_GEN: d.gen_pend = cfg_wdata;
                default: d.gen_pend = q.gen_pend;
            endcase
        end
        if (cfg_accept) begin
            d.ch_act = q.ch_pend;
            d.gen_act = q.gen_pend;
        end else if (cfg_refuse) begin
            d.ch_pend = q.ch_act;
            d.gen_pend = q.gen_act;
        end
        // averaging memory
        if (tick_p) begin
            d.fifo[q.wp] = pos_in;
            d.sum = q.sum - SW'(q.fifo[q.wp]) + SW'(pos_in);
            d.wp = q.wp + AVG_LOG2'(1);
            d.mean = 32'(q.sum >> AVG_LOG2);
        end
        // startup after supply or service exit
        if (!supply_ok || service_mode) begin
            d.run = 1'b0;
            d.start = '0;
        end else if (!q.run && tick_p) begin
            d.start = q.start + 8'h01;
            if (q.start == 8'(spoc_pkg::STARTUP_MS - 1)) begin
                d.run = 1'b1;
            end
        end
        // switching input
        if (!q.gen_act[spoc_pkg::GEN_IMODE_BIT]) begin
            d.stopped = 1'b0;
            d.in_cnt = '0;
        end else if (q.isy[1] == q.stopped) begin
            d.in_cnt = '0;
        end else if (tick_p) begin
            d.in_cnt = q.in_cnt + 4'h1;
            if (q.in_cnt >= q.gen_act[spoc_pkg::GEN_IDLY_LSB +: 4]) begin
                d.stopped = q.isy[1];
                d.in_cnt = '0;
            end
        end
        // channel scaling and overflow
        for (int c = 0; c < 2; c++) begin
            cc = q.ch_act[c];
            scaled = q.mean / f_div(cc[spoc_pkg::CH_RES_LSB +: 3]);
            w = f_width(cc[spoc_pkg::CH_WID_LSB +: 3]);
            ovf[c] = ((scaled >> w) != 0) || (scaled == '0)
                || cc[spoc_pkg::CH_RES_LSB +: 3] < spoc_pkg::RES_10UM
                || cc[spoc_pkg::CH_RES_LSB +: 3] > spoc_pkg::RES_1MM
                || cc[spoc_pkg::CH_WID_LSB +: 3] < spoc_pkg::WID_CODE_MIN
                || cc[spoc_pkg::CH_WID_LSB +: 3] > spoc_pkg::WID_CODE_MAX;
        end
        // external error with reaction time, self clearing
        raw = (|ovf) || quality_loss || q.stopped;
        if (raw) begin
            if (tick_p && !q.err) begin
                d.react = q.react + 9'h001;
            end
            d.err = q.react >= spoc_pkg::f_react_ms(
                q.gen_act[spoc_pkg::GEN_REACT_LSB +: 3]);
        end else begin
            d.react = '0;
            d.err = 1'b0;
        end
        frame_err = q.err || !q.run || device_err;
        // switching output
        unique case (q.gen_act[spoc_pkg::GEN_OSEL_LSB +: 2])
            spoc_pkg::OSEL_INVALID: cond = pos_invalid || frame_err;
            spoc_pkg::OSEL_WARN: cond = quality_warn;
            spoc_pkg::OSEL_QERR: cond = quality_loss;
            spoc_pkg::OSEL_DEVERR: cond = device_err;
        endcase
        if (!cond) begin
            d.out_cnt = '0;
        end else if (tick_p
            && q.out_cnt < q.gen_act[spoc_pkg::GEN_ODLY_LSB +: 4]) begin
            d.out_cnt = q.out_cnt + 4'h1;
        end
        d.sw_out = (cond
            && q.out_cnt >= q.gen_act[spoc_pkg::GEN_ODLY_LSB +: 4])
            ^ q.gen_act[spoc_pkg::GEN_OINV_BIT];
        // serial channels
        for (int c = 0; c < 2; c++) begin
            cc = q.ch_act[c];
            rise[c] = q.lsy[c][1] && !q.lsy[c][2];
            fall[c] = !q.lsy[c][1] && q.lsy[c][2];
            mono = cc[spoc_pkg::CH_RNG_BIT]
                ? 12'(spoc_pkg::MONO_HI_CYC)
                : 12'(spoc_pkg::MONO_LO_CYC);
            w = f_width(cc[spoc_pkg::CH_WID_LSB +: 3]);
            n = w + int'(cc[spoc_pkg::CH_ERR_BIT]);
            scaled = q.mean / f_div(cc[spoc_pkg::CH_RES_LSB +: 3]);
            scaled = scaled & ((32'h0000_0001 << w) - 32'h0000_0001);
            coded = (c == 0) ^ q.gen_act[spoc_pkg::GEN_ENC_BIT]
                ? scaled ^ (scaled >> 1) : scaled;
            if (cc[spoc_pkg::CH_ERR_BIT]) begin
                val = {coded[26:0], frame_err};
            end else begin
                val = {1'b0, coded[26:0]};
            end
            if (!q.busy[c]) begin
                if (fall[c]) begin
                    d.busy[c] = 1'b1;
                    d.sh[c] = val << (spoc_pkg::SR_LEN - n);
                    d.bits[c] = '0;
                    d.idle[c] = '0;
                end
            end else begin
                d.idle[c] = (rise[c] || fall[c]) ? '0 : q.idle[c] + 12'h001;
                if (rise[c]) begin
                    d.sdo[c] = (int'(q.bits[c]) < n) && q.sh[c][27];
                    d.sh[c] = q.sh[c] << 1;
                    d.bits[c] = (int'(q.bits[c]) < n) ? q.bits[c] + 5'h01
                        : q.bits[c];
                end
                if (q.idle[c] >= mono - 12'h001) begin
                    d.busy[c] = 1'b0;
                    d.sdo[c] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.data_a = q.sdo[0];
    assign link.data_b = q.sdo[1];
    assign rb_ch_a = q.ch_pend[0];
    assign rb_ch_b = q.ch_pend[1];
    assign rb_gen = q.gen_pend;
    assign switch_out = q.sw_out;
    assign ext_error = q.err;
    assign running = q.run;
endmodule

// ===== rtl/spoc_host.sv
// serial master end: APB slave registers, clock divider, frame capture
// assumes APB master on pclk; device data pins are asynchronous
`timescale 1ns/100ps
module spoc_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    spoc_link_if.host link
);
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} spoc_hst_e;

    typedef struct packed {
        spoc_hst_e st;
        logic [15:0] cnt;
        logic [4:0] bits;
        logic [1:0][1:0] dsy;
        logic [1:0] clk;
        logic [1:0] en;
        logic [15:0] div;
        logic [4:0] nbits;
        logic [15:0] gap;
        logic done;
        logic [1:0][31:0] sh;
        logic [1:0][31:0] rdat;
        logic rdy;
        logic [31:0] rd;
        logic err;
    } spoc_hst_s;

    function automatic spoc_hst_s f_rst();
        f_rst = '0;
        f_rst.clk = '1;
        f_rst.en = '1;
        f_rst.div = spoc_pkg::DIV_RST;
        f_rst.nbits = spoc_pkg::NBITS_RST;
        f_rst.gap = spoc_pkg::GAP_RST;
    endfunction

    localparam spoc_hst_s HST_RST = f_rst();

    spoc_hst_s q;
    spoc_hst_s d;
    logic wr;
    logic start;

    // ****************************************
    // registers and frame engine
    // ****************************************
    always_comb begin
        d = q;
        start = 1'b0;
        d.dsy[0] = {q.dsy[0][0], link.data_a};
        d.dsy[1] = {q.dsy[1][0], link.data_b};
        d.rdy = psel && penable && !q.rdy;
        wr = psel && penable && q.rdy && pwrite;
        if (psel && penable && !q.rdy) begin
            d.err = 1'b0;
            unique case (paddr)
                spoc_pkg::REG_CTRL: d.rd = {29'h0, q.en, 1'b0};
                spoc_pkg::REG_DIV: d.rd = {16'h0, q.div};
                spoc_pkg::REG_NBITS: d.rd = {27'h0, q.nbits};
                spoc_pkg::REG_GAP: d.rd = {16'h0, q.gap};
                spoc_pkg::REG_STAT: d.rd = {30'h0, q.done, q.st != H_IDLE};
                spoc_pkg::REG_DATA_A: d.rd = q.rdat[0];
                spoc_pkg::REG_DATA_B: d.rd = q.rdat[1];
                default: begin
                    d.rd = '0;
                    d.err = 1'b1;
                end
            endcase
        end
        if (wr) begin
            unique case (paddr)
                spoc_pkg::REG_CTRL: begin
                    d.en = pwdata[2:1];
                    start = pwdata[0];
                end
                spoc_pkg::REG_DIV: begin
                    if (pwdata < 32'(spoc_pkg::DIV_MIN)) begin
                        d.div = 16'(spoc_pkg::DIV_MIN);
                    end else if (pwdata > 32'(spoc_pkg::DIV_MAX)) begin
                        d.div = 16'(spoc_pkg::DIV_MAX);
                    end else begin
                        d.div = pwdata[15:0];
                    end
                end
                spoc_pkg::REG_NBITS: d.nbits = (pwdata[4:0] == '0)
                    ? 5'h01 : pwdata[4:0];
                spoc_pkg::REG_GAP: d.gap =
                    (pwdata < 32'(spoc_pkg::MONO_LO_CYC))
                    ? 16'(spoc_pkg::MONO_LO_CYC)
                    : pwdata[15:0];
                spoc_pkg::REG_STAT: if (pwdata[1]) d.done = 1'b0;
                default: d.done = q.done;
            endcase
        end
        unique case (q.st)
            H_IDLE: if (start) begin
                d.st = H_LOW;
                d.clk = ~d.en;
                d.cnt = d.div - 16'h0001;
                d.bits = '0;
                d.sh = '0;
            end
            H_LOW: if (q.cnt == '0) begin
                d.st = H_HIGH;
                d.clk = '1;
                d.cnt = q.div - 16'h0001;
            end else begin
                d.cnt = q.cnt - 16'h0001;
            end
            H_HIGH: if (q.cnt == '0) begin
                d.sh[0] = {q.sh[0][30:0], q.dsy[0][1]};
                d.sh[1] = {q.sh[1][30:0], q.dsy[1][1]};
                d.bits = q.bits + 5'h01;
                if (q.bits + 5'h01 == q.nbits) begin
                    d.st = H_GAP;
                    d.cnt = q.gap - 16'h0001;
                    d.rdat = d.sh;
                    d.done = 1'b1;
                end else begin
                    d.st = H_LOW;
                    d.clk = ~q.en;
                    d.cnt = q.div - 16'h0001;
                end
            end else begin
                d.cnt = q.cnt - 16'h0001;
            end
            H_GAP: if (q.cnt == '0) begin
                d.st = H_IDLE;
            end else begin
                d.cnt = q.cnt - 16'h0001;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= HST_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rd;
    assign pready = q.rdy;
    assign pslverr = q.err;
    assign link.clk_a = q.clk[0];
    assign link.clk_b = q.clk[1];
endmodule

// ===== rtl/spoc_link_if.sv
// two serial position channels: master clocks, device answers
// assumes the bench resolves nothing; all pins are one-way
`timescale 1ns/100ps
interface spoc_link_if;
    logic clk_a;
    logic clk_b;
    logic data_a;
    logic data_b;
    modport dev(input clk_a, input clk_b, output data_a, output data_b);
    modport host(output clk_a, output clk_b, input data_a, input data_b);
endinterface

// ===== rtl/spoc_pkg.sv
// constants shared by both ends of the dual-channel serial position link
// assumes a 100 MHz pclk on both ends
package spoc_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    localparam int MONO_HI_NS = 20_000;
    localparam int MONO_LO_NS = 30_000;
    localparam int MONO_HI_CYC = (MONO_HI_NS + CLK_NS - 1) / CLK_NS;
    localparam int MONO_LO_CYC = (MONO_LO_NS + CLK_NS - 1) / CLK_NS;
    localparam int FMAX_KHZ = 800;
    localparam int FMIN_KHZ = 50;
    // half period in cycles: 500000 ns*kHz / (kHz * ns)
    localparam int DIV_MIN = (500_000 + FMAX_KHZ * CLK_NS - 1)
        / (FMAX_KHZ * CLK_NS);
    localparam int DIV_MAX = 500_000 / (FMIN_KHZ * CLK_NS);
    localparam int STARTUP_MS = 5;
    localparam int AVG_LOG2 = 3;
    // ****************************************
    // channel settings
    // ****************************************
    localparam int CH_RES_LSB = 0;
    localparam int CH_RNG_BIT = 3;
    localparam int CH_WID_LSB = 4;
    localparam int CH_ERR_BIT = 7;
    localparam logic [7:0] CH_CFG_RST = 8'hBB;
    localparam logic [2:0] RES_10UM = 3'h2;
    localparam logic [2:0] RES_100UM = 3'h3;
    localparam logic [2:0] RES_1MM = 3'h4;
    localparam logic [2:0] WID_CODE_MIN = 3'h3;
    localparam logic [2:0] WID_CODE_MAX = 3'h6;
    localparam int WID_BASE = 24;
    localparam int SR_LEN = 28;
    // ****************************************
    // general settings
    // ****************************************
    localparam int GEN_ENC_BIT = 0;
    localparam int GEN_REACT_LSB = 1;
    localparam int GEN_OSEL_LSB = 4;
    localparam int GEN_OINV_BIT = 6;
    localparam int GEN_IMODE_BIT = 7;
    localparam int GEN_ODLY_LSB = 8;
    localparam int GEN_IDLY_LSB = 12;
    localparam logic [15:0] GEN_CFG_RST = 16'h0000;
    localparam logic [1:0] OSEL_INVALID = 2'h0;
    localparam logic [1:0] OSEL_WARN = 2'h1;
    localparam logic [1:0] OSEL_QERR = 2'h2;
    localparam logic [1:0] OSEL_DEVERR = 2'h3;
    localparam logic [1:0] CSEL_A = 2'h0;
    localparam logic [1:0] CSEL_B = 2'h1;
    localparam logic [1:0] CSEL_GEN = 2'h2;
    // ****************************************
    // controller registers
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIV = 8'h04;
    localparam logic [7:0] REG_NBITS = 8'h08;
    localparam logic [7:0] REG_GAP = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_DATA_A = 8'h14;
    localparam logic [7:0] REG_DATA_B = 8'h18;
    localparam logic [15:0] DIV_RST = 16'h003F;
    localparam logic [4:0] NBITS_RST = 5'h19;
    localparam logic [15:0] GAP_RST = 16'h0BB8;

    function automatic logic [8:0] f_react_ms(input logic [2:0] code);
        unique case (code)
            3'h0: f_react_ms = 9'h00A;
            3'h1: f_react_ms = 9'h014;
            3'h2: f_react_ms = 9'h032;
            3'h3: f_react_ms = 9'h064;
            3'h4: f_react_ms = 9'h0C8;
            default: f_react_ms = 9'h190;
        endcase
    endfunction
endpackage

// ===== verification/spoc_link_asserts.sv
// checker for the serial position link between host and device ends
// assumes pclk at 100 MHz and a host divider within 63..1000 cycles
`timescale 1ns/100ps
module spoc_link_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_a,
    input wire logic clk_b,
    input wire logic data_a,
    input wire logic data_b
);
    // ****************************************
    // cycles since each link clock last moved
    // ****************************************
    logic ca_q;
    logic cb_q;
    logic [15:0] na_q;
    logic [15:0] nb_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ca_q <= 1'b1;
            cb_q <= 1'b1;
            na_q <= 16'hFFFF;
            nb_q <= 16'hFFFF;
        end else begin
            ca_q <= clk_a;
            cb_q <= clk_b;
            na_q <= (clk_a != ca_q) ? 16'h0000
                : na_q + {15'h0000, ~&na_q};
            nb_q <= (clk_b != cb_q) ? 16'h0000
                : nb_q + {15'h0000, ~&nb_q};
        end
    end
    // ****************************************
    // wire timing
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    lowa_len_a: assert property (
        clk_a && !ca_q |-> na_q >= 16'h003E && na_q <= 16'h03E7)
        else $error("clock a low phase out of range");
    lowb_len_a: assert property (
        clk_b && !cb_q |-> nb_q >= 16'h003E && nb_q <= 16'h03E7)
        else $error("clock b low phase out of range");
    gapa_len_a: assert property (
        !clk_a && ca_q |-> na_q <= 16'h03E7 || na_q >= 16'h0BB7)
        else $error("clock a frame gap too short");
    gapb_len_a: assert property (
        !clk_b && cb_q |-> nb_q <= 16'h03E7 || nb_q >= 16'h0BB7)
        else $error("clock b frame gap too short");
    edga_data_a: assert property (
        $changed(data_a) |-> clk_a && (na_q <= 16'h0007 || na_q >= 16'h07CE))
        else $error("data a moved outside its slot");
    edgb_data_a: assert property (
        $changed(data_b) |-> clk_b && (nb_q <= 16'h0007 || nb_q >= 16'h07CE))
        else $error("data b moved outside its slot");
    idla_data_a: assert property (
        clk_a && na_q >= 16'h0C1C |-> data_a)
        else $error("data a not idle after timeout");
    idlb_data_a: assert property (
        clk_b && nb_q >= 16'h0C1C |-> data_b)
        else $error("data b not idle after timeout");
endmodule

// ===== verification/spoc_link_tb.sv
// self-checking bench: host and device ends joined by the link
// assumes 100 MHz pclk; device ms shortened to 100 cycles
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module spoc_link_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, rb_ch_a, rb_ch_b;
    logic [31:0] pwdata, prdata, rd, da, db, pos_in;
    logic quality_loss, supply_ok, cfg_wr, cfg_accept, cfg_refuse;
    logic service_mode, switch_in;
    logic [1:0] cfg_sel;
    logic [15:0] cfg_wdata, rb_gen;
    logic switch_out, ext_error, running;
    int mismatches, n_checks;
    spoc_link_if link();
    spoc_host spoc_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    spoc_device #(.MS_CYC(100)) spoc_device_i (.pclk(pclk),
        .presetn(presetn), .link(link), .pos_in(pos_in),
        .pos_invalid(1'b0), .quality_warn(1'b0),
        .quality_loss(quality_loss), .device_err(1'b0),
        .supply_ok(supply_ok), .service_mode(service_mode),
        .switch_in(switch_in), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
        .cfg_wdata(cfg_wdata), .cfg_accept(cfg_accept),
        .cfg_refuse(cfg_refuse), .rb_ch_a(rb_ch_a), .rb_ch_b(rb_ch_b),
        .rb_gen(rb_gen), .switch_out(switch_out), .ext_error(ext_error),
        .running(running));
    spoc_link_asserts spoc_link_asserts_i (.pclk(pclk), .presetn(presetn),
        .clk_a(link.clk_a), .clk_b(link.clk_b), .data_a(link.data_a),
        .data_b(link.data_b));
    // ****************************************
    // access tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) mismatches++;
    endtask
    task automatic cfg(input logic [1:0] s, input logic [15:0] d);
        @(posedge pclk);
        cfg_wr <= 1'b1;
        cfg_sel <= s;
        cfg_wdata <= d;
        @(posedge pclk);
        cfg_wr <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic decide(input logic acc);
        @(posedge pclk);
        cfg_accept <= acc;
        cfg_refuse <= !acc;
        @(posedge pclk);
        cfg_accept <= 1'b0;
        cfg_refuse <= 1'b0;
        repeat (1500) @(posedge pclk);
    endtask
    task automatic frame();
        int k;
        // a start during the previous frame's gap would be ignored
        k = 0;
        do begin
            apb(1'b0, spoc_pkg::REG_STAT, 32'h0000_0000);
            k++;
        end while (rd[0] !== 1'b0 && k < 2000);
        if (k >= 2000) mismatches++;
        apb(1'b1, spoc_pkg::REG_CTRL, 32'h0000_0007);
        k = 0;
        do begin
            repeat (100) @(posedge pclk);
            apb(1'b0, spoc_pkg::REG_STAT, 32'h0000_0000);
            k++;
        end while (rd[1] !== 1'b1 && k < 200);
        if (k >= 200) mismatches++;
        apb(1'b1, spoc_pkg::REG_STAT, 32'h0000_0002);
        apb(1'b0, spoc_pkg::REG_DATA_A, 32'h0000_0000);
        da = rd;
        apb(1'b0, spoc_pkg::REG_DATA_B, 32'h0000_0000);
        db = rd;
    endtask
    task automatic wait_err(input logic v);
        int k;
        k = 0;
        while (ext_error !== v && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        `CHK(ext_error, v)
    endtask
    function automatic logic [31:0] gray(input logic [31:0] v);
        return v ^ (v >> 1);
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****************************************
    // clock, watchdog and tests
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #1_000_000;
        mismatches++;
        give_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, cfg_wr, cfg_accept} = 6'h00;
        {cfg_refuse, quality_loss, service_mode, switch_in, supply_ok} = 5'h01;
        {paddr, pwdata, cfg_sel, cfg_wdata} = 58'h0;
        pos_in = 32'h0001_E208;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h1C, 32'h0000_0000);
        `CHK({err, rd}, 33'h1_0000_0000)
        `CHK({rb_ch_a, rb_ch_b, rb_gen}, 32'hBBBB_0000)
        repeat (1500) @(posedge pclk);
        `CHK(running, 1'b1)
        service_mode <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(running, 1'b0)
        service_mode <= 1'b0;
        repeat (600) @(posedge pclk);
        `CHK(running, 1'b1)
        frame();
        `CHK(da, gray(32'h0000_3034) << 1)
        `CHK(db, 32'h0000_6068)
        quality_loss <= 1'b1;
        repeat (500) @(posedge pclk);
        `CHK(ext_error, 1'b0)
        wait_err(1'b1);
        frame();
        `CHK(da[0], 1'b1)
        `CHK(switch_out, 1'b1)
        quality_loss <= 1'b0;
        wait_err(1'b0);
        frame();
        `CHK(da[0], 1'b0)
        `CHK(switch_out, 1'b0)
        cfg(2'h0, 16'h006C);
        `CHK(rb_ch_a, 8'h6C)
        decide(1'b0);
        `CHK(rb_ch_a, 8'hBB)
        frame();
        `CHK(da, gray(32'h0000_3034) << 1)
        cfg(2'h0, 16'h006C);
        cfg(2'h1, 16'h006A);
        cfg(2'h2, 16'h0001);
        decide(1'b1);
        apb(1'b1, spoc_pkg::REG_NBITS, 32'h0000_001B);
        frame();
        `CHK(da, 32'h0000_04D2)
        `CHK(db, gray(32'h0001_E208))
        cfg(2'h2, 16'h0081);
        decide(1'b1);
        switch_in <= 1'b1;
        wait_err(1'b1);
        switch_in <= 1'b0;
        wait_err(1'b0);
        pos_in <= 32'h0800_0000;
        wait_err(1'b1);
        give_verdict();
    end
endmodule
